/* File: design/exp_pkg.sv */
// Purpose: shared constants and types of the I/O expander core
// Assumes: 200 MHz system clock
// Notes:   register codes, reset values and filter timing
package exp_pkg;
  // ==========================================================
  // line sampling
  localparam int SYNC_W    = 21;
  localparam int IDX_SCL   = 0;
  localparam int IDX_SDA   = 1;
  localparam int IDX_IO    = 2;
  localparam int IDX_STRAP = 18;
  localparam int CNT_W     = 4;
  localparam logic [SYNC_W-1:0] LINE_RST = '1;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SPIKE_NS      = 50;
  localparam int FILT_CYC      = SPIKE_NS / CLK_PERIOD_NS + 1;
  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT_CYC - 1);
  localparam int INT_US        = 4;
  localparam int INT_CYC       = INT_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // bus framing
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] TX_LAST    = 4'h7;

  // ==========================================================
  // register pointer codes
  localparam logic [2:0] REG_IN0  = 3'h0;
  localparam logic [2:0] REG_IN1  = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_INV0 = 3'h4;
  localparam logic [2:0] REG_INV1 = 3'h5;
  localparam logic [2:0] REG_DIR0 = 3'h6;
  localparam logic [2:0] REG_DIR1 = 3'h7;
  localparam logic [1:0] BANK_IN  = 2'h0;
  localparam logic [1:0] BANK_OUT = 2'h1;
  localparam logic [1:0] BANK_INV = 2'h2;
  localparam logic [1:0] BANK_DIR = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [15:0] OUT_RST  = 16'hffff;
  localparam logic [15:0] INV_RST  = 16'h0000;
  localparam logic [15:0] DIR_RST  = 16'hffff;
  localparam logic [15:0] SNAP_RST = 16'hffff;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} phase_type;
endpackage : exp_pkg

/* File: design/filt_if.sv */
// Purpose: carrier between raw lines and filtered lines
// Assumes: one bit per sampled line
// Notes:   filter drives clean, core drives raw
`timescale 1ns/100ps
interface filt_if #(parameter int W = exp_pkg::SYNC_W);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : filt_if

/* File: design/line_filter.sv */
// Purpose: two-flop sync and spike filter for every sampled line
// Assumes: lines asynchronous to clk
// Notes:   a level must persist past the spike width to pass
`timescale 1ns/100ps
module line_filter (
  input wire logic clk,
  input wire logic rst,
  filt_if.filt     lines
);
  localparam int W = exp_pkg::SYNC_W;

  typedef struct packed {
    logic [W-1:0]                      s1;
    logic [W-1:0]                      s2;
    logic [W-1:0]                      clean;
    logic [W-1:0][exp_pkg::CNT_W-1:0] cnt;
  } filt_type;

  localparam filt_type FILT_RST = '{
    s1: exp_pkg::LINE_RST, s2: exp_pkg::LINE_RST,
    clean: exp_pkg::LINE_RST, cnt: '0};

  filt_type q;
  filt_type d;

  // ==========================================================
  // filter
  always_comb begin
    d = q;
    d.s1 = lines.raw;
    d.s2 = q.s1;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.clean[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] == exp_pkg::FILT_LAST) begin
        d.clean[i] = q.s2[i];                                 // [R12]
        d.cnt[i]   = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + exp_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= FILT_RST;
    end else begin
      q <= d;
    end
  end

  assign lines.clean = q.clean;

  // ==========================================================
  // checks
  property p_spike_reject;
    @(posedge clk) disable iff (rst)
      $changed(q.clean[0]) |-> ($past(q.s2[0], 1) == q.clean[0])
        && ($past(q.s2[0], 11) == q.clean[0]);
  endproperty
  a_spike_reject: assert property (p_spike_reject)                   // [R12]
    else $error("scl level passed without staying stable");
endmodule : line_filter

/* File: design/i2c_port_expander_regs.sv */
// Purpose: two-wire slave and register file of a 16-bit I/O expander
// Assumes: SCL, SDA, pins and straps are asynchronous to CLK
// Notes:   SCL is oversampled; open-drain lines use output enables
//
// What this block does
// R1 - address byte is 0100, three straps, read bit; all seven must match
// R2 - first byte after write address is the command, stored as pointer
// R3 - stored pointer selects register for later writes and reads
// R4 - codes 0-1 input, 2-3 output, 4-5 inversion, 6-7 direction
// R5 - input registers return sampled pin levels whatever the direction
// R6 - writes to input registers change nothing
// R7 - input registers have no reset value; they follow the pins
// R8 - output bits set the level of pins configured as outputs
// R9 - output bits do not touch input pins but stay stored
// R10 - output register reads return stored bits, not pin levels
// R11 - all output register bits reset to one
// R12 - spikes of 50 ns or less on SCL and SDA are ignored
// R13 - interrupt asserts within 4 us of a qualifying input change
// R14 - interrupt releases within 4 us of a clearing event
// R15 - direction one makes an input, zero an output; resets to one
// R16 - pointer toggles within its pair after every data byte
// R17 - interrupt on input-pin change; clear on return or own port read
// R18 - inversion bit one inverts the input register bit on read
// R19 - strap levels are latched at each start and must match to ack
`timescale 1ns/100ps
module i2c_port_expander_regs (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output wire logic       SDA_O,
  output wire logic       SDA_OE,
  input  wire logic       ADDR_STRAP_BIT0,
  input  wire logic       ADDR_STRAP_BIT1,
  input  wire logic       ADDR_STRAP_BIT2,
  input  wire logic [7:0] PIN_LEVEL_P0_BIT,
  input  wire logic [7:0] PIN_LEVEL_P1_BIT,
  output wire logic [7:0] DRIVE_LEVEL_P0_BIT,
  output wire logic [7:0] DRIVE_LEVEL_P1_BIT,
  output wire logic [7:0] DRIVE_EN_P0_BIT,
  output wire logic [7:0] DRIVE_EN_P1_BIT,
  output wire logic       INT_N_O,
  output wire logic       INT_N_OE
);

  // ==========================================================
  // state
  typedef struct packed {
    exp_pkg::state_type st;
    exp_pkg::phase_type ph;
    logic               rd;
    logic [3:0]         bits;
    logic [7:0]         sh;
    logic [2:0]         ptr;
    logic [2:0]         strap;
    logic               mack;
    logic [15:0]        outr;
    logic [15:0]        inv;
    logic [15:0]        dir;
    logic [15:0]        snap;
    logic               scl_p;
    logic               sda_p;
    logic               sda_oe;
    logic               int_oe;
    logic [15:0]        io_oe;
  } core_type;

  localparam core_type CORE_RST = '{
    st:     exp_pkg::ST_IDLE,
    ph:     exp_pkg::PH_ADDR,
    rd:     '0,
    bits:   '0,
    sh:     '0,
    ptr:    exp_pkg::REG_IN0,
    strap:  '0,
    mack:   '0,
    outr:   exp_pkg::OUT_RST,
    inv:    exp_pkg::INV_RST,
    dir:    exp_pkg::DIR_RST,
    snap:   exp_pkg::SNAP_RST,
    scl_p:  '1,
    sda_p:  '1,
    sda_oe: '0,
    int_oe: '0,
    io_oe:  ~exp_pkg::DIR_RST};

  core_type q;
  core_type d;

  // ==========================================================
  // helpers
  function automatic logic [7:0] half(
    input logic [15:0] v,
    input logic        hi);
    half = hi ? v[15:8] : v[7:0];
  endfunction : half

  function automatic logic [15:0] put_half(
    input logic [15:0] v,
    input logic        hi,
    input logic [7:0]  b);
    put_half = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction : put_half

  function automatic logic [7:0] read_reg(
    input logic [2:0]  p,
    input logic [15:0] lvl,
    input logic [15:0] inv,
    input logic [15:0] outr,
    input logic [15:0] dir);
    unique case (p[2:1])
      exp_pkg::BANK_IN:  read_reg = half(lvl ^ inv, p[0]);
      exp_pkg::BANK_OUT: read_reg = half(outr, p[0]);
      exp_pkg::BANK_INV: read_reg = half(inv, p[0]);
      exp_pkg::BANK_DIR: read_reg = half(dir, p[0]);
    endcase
  endfunction : read_reg

  // ==========================================================
  // line filtering
  filt_if #(.W(exp_pkg::SYNC_W)) fi ();

  assign fi.raw = {ADDR_STRAP_BIT2, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0,
                   PIN_LEVEL_P1_BIT, PIN_LEVEL_P0_BIT, SDA_I, SCL};

  line_filter u_filt (
    .clk   (CLK),
    .rst   (SYS_RST),
    .lines (fi.filt)
  );

  logic        scl;
  logic        sda;
  logic [15:0] pins;
  logic [2:0]  strap_now;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        mism;
  logic        load;
  logic        byte_done;

  assign scl       = fi.clean[exp_pkg::IDX_SCL];
  assign sda       = fi.clean[exp_pkg::IDX_SDA];
  assign pins      = fi.clean[exp_pkg::IDX_IO +: 16];                // [R5] [R7]
  assign strap_now = fi.clean[exp_pkg::IDX_STRAP +: 3];
  assign scl_rise  = scl && !q.scl_p;
  assign scl_fall  = !scl && q.scl_p;
  assign start_ev  = scl && q.scl_p && q.sda_p && !sda;
  assign stop_ev   = scl && q.scl_p && !q.sda_p && sda;
  assign mism      = |((pins ^ q.snap) & q.dir);                     // [R17]
  assign byte_done = (q.st == exp_pkg::ST_RX) && scl_fall
                     && (q.bits == exp_pkg::BYTE_BITS);

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    load = 1'b0;
    d.scl_p = scl;
    d.sda_p = sda;
    d.int_oe = mism;                                                 // [R13] [R14]
    if (start_ev) begin
      d.st = exp_pkg::ST_RX;
      d.ph = exp_pkg::PH_ADDR;
      d.bits = '0;
      d.sda_oe = 1'b0;
      d.strap = strap_now;                                           // [R19]
    end else if (stop_ev) begin
      d.st = exp_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        exp_pkg::ST_IDLE: begin
          d.st = exp_pkg::ST_IDLE;
        end
        exp_pkg::ST_RX: begin
          if (scl_rise && (q.bits != exp_pkg::BYTE_BITS)) begin
            d.sh = {q.sh[6:0], sda};
            d.bits = q.bits + 4'h1;
          end else if (byte_done) begin
            d.st = exp_pkg::ST_ACK;
            d.sda_oe = 1'b1;
            unique case (q.ph)
              exp_pkg::PH_ADDR: begin
                if (q.sh[7:1] == {exp_pkg::ADDR_FIXED, q.strap}) begin // [R1] [R19]
                  d.rd = q.sh[0];
                  d.ph = q.sh[0] ? exp_pkg::PH_DATA : exp_pkg::PH_CMD;
                end else begin
                  d.st = exp_pkg::ST_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              exp_pkg::PH_CMD: begin
                d.ptr = q.sh[2:0];                                   // [R2] [R4]
                d.ph = exp_pkg::PH_DATA;
              end
              exp_pkg::PH_DATA: begin
                unique case (q.ptr[2:1])                             // [R3] [R4]
                  exp_pkg::BANK_IN: begin
                    d.outr = q.outr;                                 // [R6]
                  end
                  exp_pkg::BANK_OUT: begin
                    d.outr = put_half(q.outr, q.ptr[0], q.sh);
                  end
                  exp_pkg::BANK_INV: begin
                    d.inv = put_half(q.inv, q.ptr[0], q.sh);
                  end
                  exp_pkg::BANK_DIR: begin
                    d.dir = put_half(q.dir, q.ptr[0], q.sh);
                  end
                endcase
                d.ptr = {q.ptr[2:1], ~q.ptr[0]};                     // [R16]
              end
              default: begin
                d.st = exp_pkg::ST_IDLE;
                d.sda_oe = 1'b0;
              end
            endcase
          end
        end
        exp_pkg::ST_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bits = '0;
            if (q.rd) begin
              load = 1'b1;
              d.st = exp_pkg::ST_TX;
            end else begin
              d.st = exp_pkg::ST_RX;
            end
          end
        end
        exp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (q.bits == exp_pkg::TX_LAST) begin
              d.st = exp_pkg::ST_MACK;
              d.sda_oe = 1'b0;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.bits = q.bits + 4'h1;
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        exp_pkg::ST_MACK: begin
          if (scl_rise) begin
            d.mack = ~sda;
          end else if (scl_fall) begin
            if (q.mack) begin
              load = 1'b1;
              d.bits = '0;
              d.st = exp_pkg::ST_TX;
            end else begin
              d.st = exp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          d.st = exp_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
    if (load) begin
      d.sh = read_reg(q.ptr, pins, q.inv, q.outr, q.dir);            // [R3] [R10] [R18]
      d.sda_oe = ~d.sh[7];
      d.ptr = {q.ptr[2:1], ~q.ptr[0]};                               // [R16]
      if (q.ptr[2:1] == exp_pkg::BANK_IN) begin
        d.snap = put_half(q.snap, q.ptr[0], half(pins, q.ptr[0]));   // [R17]
      end
    end
    d.io_oe = ~d.dir;                                                // [R15]
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= CORE_RST;                                                 // [R11] [R15]
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign SDA_O              = 1'b0;
  assign SDA_OE             = q.sda_oe;
  assign INT_N_O            = 1'b0;
  assign INT_N_OE           = q.int_oe;
  assign DRIVE_LEVEL_P0_BIT = q.outr[7:0];                           // [R8] [R9]
  assign DRIVE_LEVEL_P1_BIT = q.outr[15:8];
  assign DRIVE_EN_P0_BIT    = q.io_oe[7:0];                          // [R8] [R9]
  assign DRIVE_EN_P1_BIT    = q.io_oe[15:8];

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_addr_done;
    byte_done && (q.ph == exp_pkg::PH_ADDR);
  endsequence

  sequence s_data_done;
    byte_done && (q.ph == exp_pkg::PH_DATA);
  endsequence

  property p_addr_miss;
    s_addr_done ##0 (q.sh[7:1] != {exp_pkg::ADDR_FIXED, q.strap})
      |=> (q.st == exp_pkg::ST_IDLE) && !SDA_OE ##1 !SDA_OE;
  endproperty
  a_addr_miss: assert property (p_addr_miss)                         // [R1]
    else $error("ack given to a foreign address");

  property p_addr_hit;
    s_addr_done ##0 (q.sh[7:1] == {exp_pkg::ADDR_FIXED, q.strap})
      |=> SDA_OE && (q.rd == $past(q.sh[0]));
  endproperty
  a_addr_hit: assert property (p_addr_hit)                           // [R19]
    else $error("matching address not acknowledged");

  property p_cmd_ptr;
    byte_done && (q.ph == exp_pkg::PH_CMD)
      |=> (q.ptr == $past(q.sh[2:0])) && (q.ph == exp_pkg::PH_DATA);
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr)                             // [R2]
    else $error("command byte not stored as pointer");

  property p_ro_input;
    s_data_done ##0 (q.ptr[2:1] == exp_pkg::BANK_IN)
      |=> $stable(q.outr) && $stable(q.inv) && $stable(q.dir);
  endproperty
  a_ro_input: assert property (p_ro_input)                           // [R6]
    else $error("write to input register changed state");

  property p_ptr_toggle;
    s_data_done |=> (q.ptr == {$past(q.ptr[2:1]), ~$past(q.ptr[0])});
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle)                       // [R16]
    else $error("pointer did not move to pair partner");

  property p_out_read;
    load && (q.ptr == exp_pkg::REG_OUT0) |=> (q.sh == $past(q.outr[7:0]));
  endproperty
  a_out_read: assert property (p_out_read)                           // [R10]
    else $error("output read not from stored bits");

  property p_in_read;
    load && (q.ptr == exp_pkg::REG_IN1)
      |=> (q.sh == ($past(pins[15:8]) ^ $past(q.inv[15:8])));
  endproperty
  a_in_read: assert property (p_in_read)                             // [R18]
    else $error("input read lost level or inversion");

  property p_int_set;
    mism ##1 mism |-> INT_N_OE;
  endproperty
  a_int_set: assert property (p_int_set)                             // [R13]
    else $error("interrupt late after input change");

  property p_int_clr;
    !mism ##1 !mism |-> !INT_N_OE;
  endproperty
  a_int_clr: assert property (p_int_clr)                             // [R14]
    else $error("interrupt not released");

  property p_read_clear;
    load && (q.ptr == exp_pkg::REG_IN0)
      |=> (q.snap[7:0] == $past(pins[7:0])) && $stable(q.snap[15:8]);
  endproperty
  a_read_clear: assert property (p_read_clear)                       // [R17]
    else $error("port read did not rearm its own change detect");

  property p_dir_drive;
    $changed(q.dir) |-> ({DRIVE_EN_P1_BIT, DRIVE_EN_P0_BIT} == ~q.dir);
  endproperty
  a_dir_drive: assert property (p_dir_drive)                         // [R15]
    else $error("pin enable does not follow direction");
endmodule : i2c_port_expander_regs

/* File: verif/i2c_master_model.sv */
// Purpose: two-wire bus master model for the expander bench
// Assumes: link clock times every bus phase; data line has a pull-up
// Notes:   releasing data means driving 1; scl idles high between frames
`timescale 1ns/100ps
module i2c_master_model #(
  parameter int QTR = 10
) (
  input  wire logic clk_link,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  logic glitch;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
    glitch  = 1'b0;
  end

  // ==========================================================
  // bus phases
  task automatic qwait();
    repeat (QTR) @(negedge clk_link);
  endtask : qwait

  task automatic start_cond();
    qwait();
    sda_drv = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b0;
    qwait();
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    qwait();
    sda_drv = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b1;
    qwait();
  endtask : stop_cond

  // one bit; short scl spike first when asked
  task automatic bit_x(input logic b, output logic r);
    qwait();
    if (glitch) begin
      scl = 1'b1;
      #40;
      scl = 1'b0;
      glitch = 1'b0;
    end
    sda_drv = b;
    qwait();
    scl = 1'b1;
    qwait();
    r = sda_line;
    qwait();
    scl = 1'b0;
  endtask : bit_x

  // msb first, then ack slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : i2c_master_model

/* File: verif/i2c_port_expander_regs_tb.sv */
// Purpose: self-checking bench of the I/O expander register block
// Assumes: behavioural master on a 6 ns link clock
// Notes:   reference model holds registers and pointer
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module i2c_port_expander_regs_tb;
  logic        clk;
  logic        clk_link;
  logic        sys_rst;
  logic        scl;
  logic        sda_drv;
  logic        sda_oe;
  logic [2:0]  strap;
  logic [15:0] ext;
  logic [7:0]  lvl0;
  logic [7:0]  lvl1;
  logic [7:0]  en0;
  logic [7:0]  en1;
  logic        int_oe;
  logic        sda_o;
  logic        int_o;
  logic [7:0]  rm [8];
  int          ptr;
  int          mismatches;
  int          samples_checked;
  wire logic        sda_line = sda_drv & ~(sda_oe & ~sda_o);
  wire logic [15:0] pins = ({en1, en0} & {lvl1, lvl0}) | (~{en1, en0} & ext);

  always #2.5 clk = ~clk;
  always #3 clk_link = ~clk_link;

  i2c_master_model u_m (
    .clk_link (clk_link),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  i2c_port_expander_regs u_dut (
    .CLK                (clk),
    .SYS_RST            (sys_rst),
    .SCL                (scl),
    .SDA_I              (sda_line),
    .SDA_O              (sda_o),
    .SDA_OE             (sda_oe),
    .ADDR_STRAP_BIT0    (strap[0]),
    .ADDR_STRAP_BIT1    (strap[1]),
    .ADDR_STRAP_BIT2    (strap[2]),
    .PIN_LEVEL_P0_BIT   (pins[7:0]),
    .PIN_LEVEL_P1_BIT   (pins[15:8]),
    .DRIVE_LEVEL_P0_BIT (lvl0),
    .DRIVE_LEVEL_P1_BIT (lvl1),
    .DRIVE_EN_P0_BIT    (en0),
    .DRIVE_EN_P1_BIT    (en1),
    .INT_N_O            (int_o),
    .INT_N_OE           (int_oe)
  );

  // ==========================================================
  // reference model
  function automatic logic [7:0] exp_reg(input int p);
    logic [15:0] dm;
    logic [15:0] pe;
    dm = {rm[7], rm[6]};
    pe = (~dm & {rm[3], rm[2]}) | (dm & ext);
    if (p < 2) begin
      return pe[8*p+:8] ^ rm[4+p];
    end
    return rm[p];
  endfunction : exp_reg

  // ==========================================================
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic wait_int(input logic e);
    int n = 0;
    while (int_oe !== e && n < exp_pkg::INT_CYC) begin
      @(negedge clk);
      n++;
    end
    `CHK(int_oe, e)
    `CHK(int_o, 1'b0)
    if (int_oe !== e) begin
      finish_test();
    end
  endtask : wait_int

  task automatic chk_port();
    `CHK({en1, en0}, ~{rm[7], rm[6]})
    `CHK({lvl1, lvl0}, {rm[3], rm[2]})
  endtask : chk_port

  task automatic cmd_phase(input logic [2:0] cmd);
    logic ack;
    u_m.start_cond();
    u_m.wr_byte({exp_pkg::ADDR_FIXED, strap, 1'b0}, ack);
    `CHK(ack, 1'b1)
    u_m.wr_byte({5'h00, cmd}, ack);
    `CHK(ack, 1'b1)
    ptr = int'(cmd);
  endtask : cmd_phase

  task automatic wr_regs(input logic [2:0] cmd, input logic [23:0] d, input int n);
    logic ack;
    cmd_phase(cmd);
    for (int i = 0; i < n; i++) begin
      u_m.wr_byte(d[8*i+:8], ack);
      `CHK(ack, 1'b1)
      if (ptr >= 2) begin
        rm[ptr] = d[8*i+:8];
      end
      ptr = ptr ^ 1;
    end
    u_m.stop_cond();
    chk_port();
  endtask : wr_regs

  task automatic rd_regs(input logic [2:0] cmd, input int n);
    logic       ack;
    logic [7:0] b;
    cmd_phase(cmd);
    u_m.start_cond();
    u_m.wr_byte({exp_pkg::ADDR_FIXED, strap, 1'b1}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_m.rd_byte(i == n - 1, b);
      `CHK(b, exp_reg(ptr))
      ptr = ptr ^ 1;
    end
    u_m.stop_cond();
  endtask : rd_regs

  task automatic probe(input logic [3:0] hi, input logic [2:0] a);
    logic ack;
    u_m.start_cond();
    u_m.wr_byte({hi, a, 1'b0}, ack);
    u_m.stop_cond();
    `CHK(ack, hi == exp_pkg::ADDR_FIXED && a == strap)
  endtask : probe

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    clk_link = 1'b0;
    sys_rst = 1'b1;
    strap = 3'h5;
    ext = 16'hffff;
    mismatches = 0;
    samples_checked = 0;
    rm = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    void'($urandom(45));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (20) @(negedge clk);
    chk_port();
    rd_regs(3'h2, 2);
    rd_regs(3'h4, 4);
    rd_regs(3'h7, 2);
    for (int s = 0; s < 8; s++) begin
      @(negedge clk);
      strap = 3'(s);
      probe(exp_pkg::ADDR_FIXED, 3'(s));
      probe(exp_pkg::ADDR_FIXED, 3'(s + 3));
    end
    for (int k = 0; k < 4; k++) begin
      probe(exp_pkg::ADDR_FIXED ^ 4'(1 << k), strap);
    end
    // interrupt set, port read clear, return clear
    rd_regs(3'h0, 2);
    @(negedge clk);
    ext[3] = 1'b0;
    wait_int(1'b1);
    rd_regs(3'h1, 1);
    `CHK(int_oe, 1'b1)
    rd_regs(3'h0, 1);
    wait_int(1'b0);
    @(negedge clk);
    ext[3] = 1'b1;
    wait_int(1'b1);
    @(negedge clk);
    ext[3] = 1'b0;
    wait_int(1'b0);
    // output pins never interrupt
    wr_regs(3'h6, 24'h000000, 2);
    rd_regs(3'h0, 2);
    wr_regs(3'h2, 24'($urandom), 2);
    repeat (exp_pkg::INT_CYC) @(negedge clk);
    `CHK(int_oe, 1'b0)
    // every command, random data and pins
    for (int c = 0; c < 8; c++) begin
      @(negedge clk);
      ext = 16'($urandom);
      wr_regs(3'(c), 24'($urandom), 3);
      rd_regs(3'(c ^ 1), 2);
    end
    rd_regs(3'h0, 2);
    // spike on scl during a write
    u_m.glitch = 1'b1;
    wr_regs(3'h3, 24'($urandom), 1);
    rd_regs(3'h3, 1);
    finish_test();
  end
endmodule : i2c_port_expander_regs_tb
